// >>> rtl/ddr2_cmd_pkg.sv
// Shared constants for the DDR2 command, bank and refresh logic
package ddr2_cmd_pkg;
    localparam int NUM_BANKS    = 8;
    localparam int BANK_W       = 3;
    localparam int ROW_W        = 13;
    localparam int COL_W        = 10;
    localparam int AP_BIT       = 10;
    localparam int AL_MAX       = 6;
    localparam int AL_W         = 3;
    localparam int WR_W         = 3;
    localparam int CNT_W        = 6;
    localparam int REF_ROW_W    = 13;
    // Internal self refresh timer: 7.8 us interval at 20 MHz
    localparam int REFI_NS      = 7800;
    localparam int CLK_NS       = 50;
    localparam int REFI_CYC     = REFI_NS / CLK_NS;
    localparam int TMR_W        = 16;
    localparam logic [AL_W-1:0]  AL_RESET = 3'h0;
    localparam logic [WR_W-1:0]  WR_RESET = 3'h2;
    localparam logic [CNT_W-1:0] BL_HALF4 = 6'h02;
    localparam logic [CNT_W-1:0] BL_HALF8 = 6'h04;
    localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA,
        CMD_REF, CMD_SRE, CMD_MRS, CMD_DESEL
    } cmd_t;
endpackage

// >>> rtl/ddr2_bank_fsm.sv
// One bank's idle/open state and auto-precharge countdown
`timescale 1ns/1ns
module ddr2_bank_fsm
    import ddr2_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Command strobes for this bank
    input  wire logic             act_in,
    input  wire logic             pre_in,
    input  wire logic             ap_start_in,
    input  wire logic [CNT_W-1:0] ap_delay_in,
    input  wire logic [ROW_W-1:0] row_in,
    // State
    output logic                  open_out,
    output logic [ROW_W-1:0]      row_out,
    output logic                  ap_busy_out
);
    logic [CNT_W-1:0] ap_cnt;

    // Open row tracking per bank; precharge wins over a pending count
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            open_out <= 1'b0;
            row_out  <= '0;
        end else if (pre_in || (ap_busy_out && ap_cnt == CNT_ONE)) begin
            open_out <= 1'b0; // see [R23]
        end else if (act_in) begin
            open_out <= 1'b1; // see [R3]
            row_out  <= row_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ap_busy_out <= 1'b0;
            ap_cnt      <= '0;
        end else if (pre_in) begin
            ap_busy_out <= 1'b0;
            ap_cnt      <= '0;
        end else if (ap_start_in) begin
            ap_busy_out <= 1'b1;
            ap_cnt      <= ap_delay_in;
        end else if (ap_busy_out) begin
            ap_cnt <= ap_cnt - CNT_ONE;
            if (ap_cnt == CNT_ONE) begin
                ap_busy_out <= 1'b0;
            end
        end
    end
endmodule // ddr2_bank_fsm

// >>> rtl/ddr2_command_bank_refresh.sv
// DDR2 command decoder with bank state, auto-precharge and refresh
// Contract
// [R1] Controller waits turn-off delay before termination write
// [R2] Controller keeps termination pin low through update
// [R3] Activate decode opens addressed bank row
// [R4] Read/write accepted next cycle, delayed by AL
// [R5] Additive latency 0 to 6 supported
// [R6] Controller precharges before reactivating; spacing timings
// [R7] Controller limits four activates per window
// [R8] Controller waits precharge time plus one after all
// [R9] Read decode; address bit ten selects auto-precharge
// [R10] Write decode; address bit ten selects auto-precharge
// [R11] Read auto-precharge starts after AL plus BL/2
// [R12] Write auto-precharge after burst and write recovery
// [R13] Precharge-all closes every bank
// [R14] Self refresh entry with clock enable low
// [R15] Controller disables termination before self refresh
// [R16] Self refresh: DLL off, internal timer, only CKE
// [R17] Controller keeps clock stable before exit
// [R18] Controller sends NOPs during exit interval
// [R19] Controller refreshes once between self refreshes
// [R20] Refresh leaves all banks idle
// [R21] Refresh rows generated internally, address ignored
// [R22] Controller refreshes at average interval
// [R23] Each bank tracks own idle or open state
`timescale 1ns/1ns
module ddr2_command_bank_refresh
    import ddr2_cmd_pkg::*;
#(
    parameter int REFI_CYCLES = REFI_CYC
)(
    // Clock and reset
    input  wire logic                 CLK_SYS_IN,
    input  wire logic                 SYS_RST_IN,
    // Command pins from the controller
    input  wire logic                 CKE_IN,
    input  wire logic                 CS_N_IN,
    input  wire logic                 RAS_N_IN,
    input  wire logic                 CAS_N_IN,
    input  wire logic                 WE_N_IN,
    input  wire logic [BANK_W-1:0]    BA_IN,
    input  wire logic [ROW_W-1:0]     ADDR_IN,
    input  wire logic                 ODT_IN,
    // Latency settings held by the mode registers
    input  wire logic [AL_W-1:0]      ADD_LAT_IN,
    input  wire logic [WR_W-1:0]      WR_REC_IN,
    input  wire logic                 BURST8_IN,
    // Bank and mode status
    output logic [NUM_BANKS-1:0]      BANK_OPEN_OUT,
    output logic                      DLL_ON_OUT,
    output logic                      SELF_REF_OUT,
    output logic                      TERM_ON_OUT,
    // Internal column command after additive latency
    output logic                      COL_VALID_OUT,
    output logic                      COL_WRITE_OUT,
    output logic [BANK_W-1:0]         COL_BANK_OUT,
    output logic [COL_W-1:0]          COL_ADDR_OUT,
    // Refresh row in progress
    output logic                      REF_PULSE_OUT,
    output logic [REF_ROW_W-1:0]      REF_ROW_OUT
);
    // Pins come from outside this clock's domain
    logic       cke_m, cke_s, cs_m, cs_s, ras_m, ras_s;
    logic       cas_m, cas_s, we_m, we_s, odt_m, odt_s;
    logic [BANK_W-1:0] ba_m, ba_s;
    logic [ROW_W-1:0]  ad_m, ad_s;

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            {cke_m, cs_m, ras_m, cas_m, we_m, odt_m} <= 6'h1e;
            {cke_s, cs_s, ras_s, cas_s, we_s, odt_s} <= 6'h1e;
            ba_m <= '0;
            ba_s <= '0;
            ad_m <= '0;
            ad_s <= '0;
        end else begin
            {cke_m, cs_m, ras_m, cas_m, we_m, odt_m} <=
                {CKE_IN, CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN, ODT_IN};
            {cke_s, cs_s, ras_s, cas_s, we_s, odt_s} <=
                {cke_m, cs_m, ras_m, cas_m, we_m, odt_m};
            ba_m <= BA_IN;
            ba_s <= ba_m;
            ad_m <= ADDR_IN;
            ad_s <= ad_m;
        end
    end

    logic  self_ref;
    logic  cke_prev;
    cmd_t  cmd;

    // Command decode; in self refresh only CKE is looked at
    always_comb begin
        cmd = CMD_NOP;
        if (self_ref) begin
            cmd = CMD_NOP; // see [R16]
        end else if (cs_s) begin
            cmd = CMD_DESEL;
        end else begin
            case ({ras_s, cas_s, we_s})
                3'h3: cmd = CMD_ACT; // see [R3]
                3'h5: cmd = CMD_RD;  // see [R9]
                3'h4: cmd = CMD_WR;  // see [R10]
                3'h2: cmd = ad_s[AP_BIT] ? CMD_PREA : CMD_PRE;
                3'h1: cmd = cke_s ? CMD_REF : CMD_SRE; // see [R14]
                3'h0: cmd = CMD_MRS;
                default: cmd = CMD_NOP;
            endcase
        end
    end

    // Additive latency clamped to the supported range
    logic [AL_W-1:0]  al_eff;
    logic [CNT_W-1:0] bl_half;
    assign al_eff  = (ADD_LAT_IN > AL_W'(AL_MAX)) ? AL_W'(AL_MAX)
                                                  : ADD_LAT_IN; // see [R5]
    assign bl_half = BURST8_IN ? BL_HALF8 : BL_HALF4;

    // Auto-precharge delays from the column command
    logic [CNT_W-1:0] rd_ap_delay, wr_ap_delay, ap_delay;
    assign rd_ap_delay = CNT_W'(al_eff) + bl_half; // see [R11]
    // Write latency AL+CL-1 is folded into a fixed CL-less bound
    assign wr_ap_delay = CNT_W'(al_eff) + bl_half
                       + CNT_W'(WR_REC_IN) + CNT_ONE; // see [R12]
    assign ap_delay = (cmd == CMD_WR) ? wr_ap_delay : rd_ap_delay;

    logic col_cmd;
    assign col_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);

    // Bank state, one instance per bank
    logic [NUM_BANKS-1:0] open_v, busy_v;
    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++) begin : g_bank
            logic sel;
            assign sel = (ba_s == BANK_W'(g));
            ddr2_bank_fsm u_bank (
                .clk_in      (CLK_SYS_IN),
                .rst_in      (SYS_RST_IN),
                .act_in      ((cmd == CMD_ACT) && sel),
                .pre_in      ((cmd == CMD_PREA) || (cmd == CMD_REF)
                              || ((cmd == CMD_PRE) && sel)), // see [R13]
                .ap_start_in (col_cmd && sel && ad_s[AP_BIT]),
                .ap_delay_in (ap_delay),
                .row_in      (ad_s),
                .open_out    (open_v[g]),
                .row_out     (),
                .ap_busy_out (busy_v[g])
            );
        end
    endgenerate

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            BANK_OPEN_OUT <= '0;
        end else begin
            BANK_OPEN_OUT <= open_v; // see [R23]
        end
    end

    // Column command held for AL cycles in a shift line
    logic [AL_MAX:0]         pv;
    logic [AL_MAX:0]         pw;
    logic [BANK_W-1:0]       pb [AL_MAX:0];
    logic [COL_W-1:0]        pc [AL_MAX:0];

    // Accepted right after activate: no spacing check here
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            pv <= '0;
            pw <= '0;
            for (int i = 0; i <= AL_MAX; i++) begin
                pb[i] <= '0;
                pc[i] <= '0;
            end
        end else begin
            for (int i = 0; i < AL_MAX; i++) begin
                pv[i] <= pv[i+1];
                pw[i] <= pw[i+1];
                pb[i] <= pb[i+1];
                pc[i] <= pc[i+1];
            end
            pv[AL_MAX] <= 1'b0;
            pw[AL_MAX] <= 1'b0;
            pb[AL_MAX] <= '0;
            pc[AL_MAX] <= '0;
            if (col_cmd) begin
                pv[al_eff] <= 1'b1; // see [R4]
                pw[al_eff] <= (cmd == CMD_WR);
                pb[al_eff] <= ba_s;
                pc[al_eff] <= ad_s[COL_W-1:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            COL_VALID_OUT <= 1'b0;
            COL_WRITE_OUT <= 1'b0;
            COL_BANK_OUT  <= '0;
            COL_ADDR_OUT  <= '0;
        end else begin
            COL_VALID_OUT <= pv[0];
            COL_WRITE_OUT <= pw[0];
            COL_BANK_OUT  <= pb[0];
            COL_ADDR_OUT  <= pc[0];
        end
    end

    // Self refresh entry and exit; exit is CKE rising
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            self_ref <= 1'b0;
            cke_prev <= 1'b1;
        end else begin
            cke_prev <= cke_s;
            if (cmd == CMD_SRE) begin
                self_ref <= 1'b1; // see [R14]
            end else if (self_ref && cke_s && !cke_prev) begin
                self_ref <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            SELF_REF_OUT <= 1'b0;
            DLL_ON_OUT   <= 1'b1;
            TERM_ON_OUT  <= 1'b0;
        end else begin
            SELF_REF_OUT <= self_ref;
            DLL_ON_OUT   <= !self_ref; // see [R16]
            // Termination is unsupported while self refreshing
            TERM_ON_OUT  <= odt_s && !self_ref;
        end
    end

    // Internal refresh timer and row counter
    logic [TMR_W-1:0]     tmr;
    logic [REF_ROW_W-1:0] ref_row;
    logic                 tmr_hit;
    assign tmr_hit = self_ref && (tmr == TMR_W'(REFI_CYCLES - 1));

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN || !self_ref) begin
            tmr <= '0;
        end else if (tmr_hit) begin
            tmr <= '0; // see [R16]
        end else begin
            tmr <= tmr + TMR_W'(1);
        end
    end

    // Address pins never feed the row counter
    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            ref_row       <= '0;
            REF_PULSE_OUT <= 1'b0;
            REF_ROW_OUT   <= '0;
        end else begin
            REF_PULSE_OUT <= 1'b0;
            if (cmd == CMD_REF || tmr_hit) begin
                ref_row       <= ref_row + REF_ROW_W'(1); // see [R21]
                REF_PULSE_OUT <= 1'b1; // see [R20]
                REF_ROW_OUT   <= ref_row;
            end
        end
    end
endmodule // ddr2_command_bank_refresh

// >>> verif/ddr2_cmd_assertions.sv
// Port-level checks for the DDR2 command, bank and refresh block
`timescale 1ns/1ns
module ddr2_cmd_assertions
    import ddr2_cmd_pkg::*;
(
    // Clock and reset
    input wire logic                 CLK_SYS_IN,
    input wire logic                 SYS_RST_IN,
    // Command pins and settings
    input wire logic                 CKE_IN,
    input wire logic                 CS_N_IN,
    input wire logic                 RAS_N_IN,
    input wire logic                 CAS_N_IN,
    input wire logic                 WE_N_IN,
    input wire logic [BANK_W-1:0]    BA_IN,
    input wire logic [ROW_W-1:0]     ADDR_IN,
    input wire logic [AL_W-1:0]      ADD_LAT_IN,
    input wire logic                 BURST8_IN,
    // Observed state
    input wire logic [NUM_BANKS-1:0] BANK_OPEN_OUT,
    input wire logic                 DLL_ON_OUT,
    input wire logic                 SELF_REF_OUT,
    input wire logic                 TERM_ON_OUT,
    input wire logic                 COL_VALID_OUT,
    input wire logic                 COL_WRITE_OUT,
    input wire logic                 REF_PULSE_OUT
);
    logic [3:0] pins;
    logic       live;
    assign pins = {CS_N_IN, RAS_N_IN, CAS_N_IN, WE_N_IN};
    assign live = CKE_IN && !SELF_REF_OUT;
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence ref_done;
        REF_PULSE_OUT ##1 (BANK_OPEN_OUT == '0);
    endsequence
    act_open_a:
        assert property (live && pins == 4'h3
            |-> ##4 BANK_OPEN_OUT[$past(BA_IN, 4)])
        else $error("bank did not open");
    prea_close_a:
        assert property (live && pins == 4'h2 && ADDR_IN[AP_BIT]
            |-> ##4 BANK_OPEN_OUT == '0)
        else $error("banks left open");
    ref_idle_a:
        assert property (live && pins == 4'h1 |-> ##3 ref_done)
        else $error("refresh pulse or idle wrong");
    col_al0_a:
        assert property (live && pins[3:1] == 3'h2 && ADD_LAT_IN == 3'h0
            |-> ##4 COL_VALID_OUT && COL_WRITE_OUT == !$past(WE_N_IN, 4))
        else $error("column command late");
    col_al6_a:
        assert property (live && pins[3:1] == 3'h2 && ADD_LAT_IN == 3'h6
            |-> ##10 COL_VALID_OUT && COL_WRITE_OUT == !$past(WE_N_IN, 10))
        else $error("column command late");
    rd_ap_a:
        assert property (live && pins == 4'h5 && ADDR_IN[AP_BIT]
            && ADD_LAT_IN == 3'h0 && !BURST8_IN
            |-> ##5 BANK_OPEN_OUT[$past(BA_IN, 5)]
            ##1 !BANK_OPEN_OUT[$past(BA_IN, 6)])
        else $error("auto precharge timing");
    sr_enter_a:
        assert property (!CKE_IN && pins == 4'h1 && !SELF_REF_OUT
            |-> ##4 SELF_REF_OUT && !DLL_ON_OUT)
        else $error("self refresh not entered");
    sr_quiet_a:
        assert property (SELF_REF_OUT && $past(SELF_REF_OUT)
            |-> !DLL_ON_OUT && !TERM_ON_OUT && !COL_VALID_OUT)
        else $error("activity in self refresh");
    sr_hold_a:
        assert property ((SELF_REF_OUT && !CKE_IN) [*5] |=> SELF_REF_OUT)
        else $error("self refresh left early");
    sr_exit_a:
        assert property (SELF_REF_OUT && $rose(CKE_IN)
            |-> ##[1:6] !SELF_REF_OUT && DLL_ON_OUT)
        else $error("self refresh exit missing");
endmodule // ddr2_cmd_assertions

bind ddr2_command_bank_refresh ddr2_cmd_assertions i_chk (
    .CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .CKE_IN(CKE_IN),
    .CS_N_IN(CS_N_IN), .RAS_N_IN(RAS_N_IN), .CAS_N_IN(CAS_N_IN),
    .WE_N_IN(WE_N_IN), .BA_IN(BA_IN), .ADDR_IN(ADDR_IN),
    .ADD_LAT_IN(ADD_LAT_IN), .BURST8_IN(BURST8_IN),
    .BANK_OPEN_OUT(BANK_OPEN_OUT), .DLL_ON_OUT(DLL_ON_OUT),
    .SELF_REF_OUT(SELF_REF_OUT), .TERM_ON_OUT(TERM_ON_OUT),
    .COL_VALID_OUT(COL_VALID_OUT), .COL_WRITE_OUT(COL_WRITE_OUT),
    .REF_PULSE_OUT(REF_PULSE_OUT));

// >>> verif/ddr2_ctl_model.sv
// Memory controller model driving the DDR2 command pins
`timescale 1ns/1ns
module ddr2_ctl_model
    import ddr2_cmd_pkg::*;
(
    // Clock
    input  wire logic        clk_in,
    // Command pins
    output logic             cke_out,
    output logic             cs_n_out,
    output logic             ras_n_out,
    output logic             cas_n_out,
    output logic             we_n_out,
    output logic [BANK_W-1:0] ba_out,
    output logic [ROW_W-1:0]  addr_out,
    output logic             odt_out
);
    initial begin
        {cke_out, cs_n_out, ras_n_out, cas_n_out, we_n_out} = 5'h1f;
        ba_out = '0;
        addr_out = '0;
        odt_out = 1'b0;
    end
    // One command per cycle; CKE stays low after entry until levels()
    task automatic issue(input cmd_t c, input logic [BANK_W-1:0] b,
                         input logic [ROW_W-1:0] a);
        logic [3:0] code;
        @(negedge clk_in);
        ba_out = b;
        addr_out = a;
        case (c)
            CMD_ACT: code = 4'h3;
            CMD_RD: code = 4'h5;
            CMD_WR: code = 4'h4;
            CMD_PRE, CMD_PREA: code = 4'h2;
            CMD_REF, CMD_SRE: code = 4'h1;
            default: begin
                // Don't-care lines toggle so a stale value never matches
                code = 4'h7;
                ba_out = ~b;
                addr_out = ~a;
            end
        endcase
        {cs_n_out, ras_n_out, cas_n_out, we_n_out} = code;
        if (c == CMD_SRE) begin
            cke_out = 1'b0;
        end
    endtask
    // Idle spacing carries tRRD, tRC, tFAW, tRP+1, tRFC and tXSNR
    task automatic nop(input int n);
        repeat (n) issue(CMD_NOP, ba_out, addr_out);
    endtask
    task automatic levels(input logic c, input logic o);
        @(negedge clk_in);
        cke_out = c;
        odt_out = o;
    endtask
endmodule // ddr2_ctl_model

// >>> verif/tb_top.sv
// Self-checking bench for the DDR2 command, bank and refresh block
`timescale 1ns/1ns
module tb_top
    import ddr2_cmd_pkg::*;
;
    localparam int REFI_T = 8;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 cke, cs_n, ras_n, cas_n, we_n, odt;
    logic                 burst8 = 1'b0;
    logic [BANK_W-1:0]    ba, col_bank;
    logic [ROW_W-1:0]     addr;
    logic [AL_W-1:0]      add_lat = AL_RESET;
    logic [WR_W-1:0]      wr_rec = WR_RESET;
    logic [NUM_BANKS-1:0] open;
    logic                 dll, sref, term, col_v, col_w, ref_p;
    logic [COL_W-1:0]     col_addr;
    logic [REF_ROW_W-1:0] ref_row;
    logic [31:0]          lfsr = 32'hbb95;
    int                   n_errors = 0;
    int                   tests_run = 0;
    always #25 clk = ~clk;
    ddr2_ctl_model i_ctl (.clk_in(clk), .cke_out(cke), .cs_n_out(cs_n),
        .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n),
        .ba_out(ba), .addr_out(addr), .odt_out(odt));
    ddr2_command_bank_refresh #(.REFI_CYCLES(REFI_T)) i_dut (
        .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CKE_IN(cke), .CS_N_IN(cs_n),
        .RAS_N_IN(ras_n), .CAS_N_IN(cas_n), .WE_N_IN(we_n), .BA_IN(ba),
        .ADDR_IN(addr), .ODT_IN(odt), .ADD_LAT_IN(add_lat),
        .WR_REC_IN(wr_rec), .BURST8_IN(burst8), .BANK_OPEN_OUT(open),
        .DLL_ON_OUT(dll), .SELF_REF_OUT(sref), .TERM_ON_OUT(term),
        .COL_VALID_OUT(col_v), .COL_WRITE_OUT(col_w),
        .COL_BANK_OUT(col_bank), .COL_ADDR_OUT(col_addr),
        .REF_PULSE_OUT(ref_p), .REF_ROW_OUT(ref_row));
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    // Close follows the column pulse by BL/2, plus WR+1 for writes
    function automatic int ap_tail(input logic w, b8, input int rec);
        return (b8 ? 4 : 2) + (w ? rec + 1 : 0);
    endfunction
    task automatic chk(input string what, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk_n(input string what, input int e, g);
        chk(what, 16'(e), 16'(g));
    endtask
    task automatic conclude();
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(50 * 4000);
        n_errors++;
        conclude();
    end
    initial begin
        logic [31:0] r;
        logic        w, ap;
        int          n;
        int          al_x;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk("reset", 16'h0010, {3'h0, open, dll, sref, term, col_v, ref_p});
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            w = i[0];
            ap = r[3] | (i == 0);
            burst8 = r[4] & (i != 0);
            // Last rounds draw AL at random, 7 included to hit the clamp
            add_lat = (i < 14) ? AL_W'(i / 2) : r[7:5];
            al_x = (int'(add_lat) > AL_MAX) ? AL_MAX : int'(add_lat);
            wr_rec = 3'h2 + {1'b0, r[6:5]};
            i_ctl.issue(CMD_ACT, r[2:0], r[20:8]);
            i_ctl.issue(w ? CMD_WR : CMD_RD, r[2:0], {2'h0, ap, r[31:22]});
            i_ctl.nop(1);
            n = 0;
            while (col_v !== 1'b1 && n < 40) begin
                i_ctl.nop(1);
                n++;
            end
            // Pulse shows 3 polls after the command, plus AL
            chk_n("col delay", 3 + al_x, n);
            chk("col", {2'h0, w, r[2:0], r[31:22]},
                {2'h0, col_w, col_bank, col_addr});
            n = 0;
            while (ap && open[r[2:0]] !== 1'b0 && n < 40) begin
                i_ctl.nop(1);
                n++;
            end
            if (ap) chk_n("ap close", ap_tail(w, burst8, wr_rec), n);
            i_ctl.issue(CMD_PREA, r[7:5], 13'h0400);
            i_ctl.nop(6);
            chk("prea", 16'h0, {8'h0, open});
        end
        i_ctl.issue(CMD_ACT, 3'h1, 13'h0);
        i_ctl.nop(2);
        i_ctl.issue(CMD_ACT, 3'h6, 13'h0);
        i_ctl.nop(4);
        chk("two open", 16'h0042, {8'h0, open});
        r = rnd();
        i_ctl.issue(CMD_REF, r[2:0], r[15:3]);
        for (n = 0; ref_p !== 1'b1 && n < 40; n++) i_ctl.nop(1);
        chk_n("ref pulse", 3, n);
        // First refresh after reset uses row zero
        chk("ref row", 16'h0, {3'h0, ref_row});
        i_ctl.nop(1);
        chk("ref idle", 16'h0, {8'h0, open});
        i_ctl.levels(1'b1, 1'b1);
        i_ctl.nop(6);
        chk("term", 16'h1, {15'h0, term});
        i_ctl.levels(1'b1, 1'b0);
        i_ctl.nop(6);
        i_ctl.issue(CMD_SRE, 3'h0, 13'h0);
        i_ctl.nop(5);
        i_ctl.issue(CMD_ACT, 3'h2, 13'h0);
        n = 0;
        repeat (4 * REFI_T) begin
            i_ctl.nop(1);
            if (ref_p === 1'b1) n++;
        end
        chk_n("sr timer", 1, n >= 3);
        chk("sr hold", 16'h0001, {6'h0, open, dll, sref});
        i_ctl.levels(1'b1, 1'b0);
        i_ctl.nop(10);
        chk("sr exit", 16'h0002, {14'h0, dll, sref});
        i_ctl.issue(CMD_REF, 3'h0, 13'h0);
        i_ctl.nop(8);
        conclude();
    end
endmodule // tb_top
